//--- pbr_pkg.sv
// Package of register indices, field positions and reset values
package pbr_pkg;
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_STAT   = 5'h01;
  localparam logic [4:0] ADDR_IDH    = 5'h02;
  localparam logic [4:0] ADDR_IDL    = 5'h03;
  localparam logic [4:0] ADDR_ADV    = 5'h04;
  localparam logic [4:0] ADDR_LPA    = 5'h05;
  localparam logic [4:0] ADDR_EXP    = 5'h06;
  localparam logic [4:0] ADDR_NPTX   = 5'h07;
  localparam logic [4:0] ADDR_LPNP   = 5'h08;
  localparam logic [4:0] ADDR_GCTL   = 5'h09;
  localparam int NUM_REGS            = 10;
  localparam int CTL_RESET_BIT       = 15;
  localparam int CTL_SPEED_LSB       = 13;
  localparam int CTL_ANEG_EN         = 12;
  localparam int CTL_PDOWN           = 11;
  localparam int CTL_ISOLATE         = 10;
  localparam int CTL_RESTART         = 9;
  localparam int CTL_DUPLEX          = 8;
  localparam int CTL_SPEED_MSB       = 6;
  localparam int CTL_UNIDIR          = 5;
  localparam logic [15:0] CTL_RST    = 16'h1040;
  localparam logic [15:0] CTL_WMASK  = 16'hFFE0;
  localparam logic [15:0] STAT_FIXED = 16'h7949;
  localparam logic [15:0] ADV_RST    = 16'h01E1;
  localparam logic [15:0] ADV_WMASK  = 16'hBFFF;
  localparam logic [15:0] NPTX_RST   = 16'h2001;
  localparam logic [15:0] NPTX_WMASK = 16'hB7FF;
  localparam logic [15:0] GCTL_RST   = 16'h0700;
  localparam logic [15:0] EXP_NP_ABLE = 16'h0004;
  localparam real SRST_WAIT_US       = 1.0;
  localparam real CLK_MHZ            = 125.0;
  localparam int SRST_CYCLES = int'(SRST_WAIT_US * CLK_MHZ);
  localparam int SRST_CNT_W  = 8;
  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10,
    SPD_RSVD = 2'b11
  } pbr_speed_t;
endpackage

//--- pbr_latch.sv
// Latched status bit that holds an event until read, then rearms
`timescale 1ns/1ns
`default_nettype none
module pbr_latch #(
  parameter logic HOLD_VAL = 1'b1
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic CE,
  input  wire logic CLR,
  input  wire logic COND,
  input  wire logic RD,
  output logic      Q
);
  logic q_r;
  logic q_nxt;
  // Event beats a read in the same cycle; a read rearms to live condition
  assign q_nxt = (COND == HOLD_VAL) ? HOLD_VAL : (RD ? COND : q_r);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      // Power-up reads as zero, link down included
      q_r <= 1'b0;
    end else if (CE) begin
      q_r <= CLR ? ~HOLD_VAL : q_nxt;
    end
  end
  assign Q = q_r;
endmodule // pbr_latch
`default_nettype wire

//--- pbr_regs.sv
// Base management register set 0..9 of one transceiver port
`timescale 1ns/1ns
`default_nettype none
module pbr_regs #(
  parameter logic [15:0] ORG_ID_HIGH = 16'h1234, // Arbitrary value
  parameter logic [5:0]  ORG_ID_LOW  = 6'h2A,    // Arbitrary value
  parameter logic [5:0]  MODEL_NUM   = 6'h15,    // Arbitrary value
  parameter logic [3:0]  REVISION    = 4'h1      // Arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        REG_WE,
  input  wire logic        REG_RE,
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output logic [15:0]      REG_RDATA,
  output logic             REG_BUSY,
  input  wire logic        LINK_UP,
  input  wire logic        FAR_FAULT,
  input  wire logic        JABBER,
  input  wire logic        ANEG_DONE,
  input  wire logic        PAR_DET_FAULT,
  input  wire logic        PAGE_RX,
  input  wire logic [15:0] LINK_PARTNER_BASE,
  input  wire logic [15:0] LINK_PARTNER_NEXT,
  input  wire logic        LINK_PARTNER_NP,
  input  wire logic        LINK_PARTNER_AN,
  input  wire logic        NP_SENT,
  input  wire logic        FIBER_MODE,
  input  wire logic        TS_ACTIVE,
  input  wire logic        CRYPTO_ACTIVE,
  input  wire logic        LEGACY_EEE,
  input  wire logic [7:0]  MAC_RX_IN,
  input  wire logic [7:0]  MAC_TX_DATA,
  output logic [7:0]       MAC_RX_OUT,
  output logic             MAC_OUT_OE_N,
  output logic [7:0]       MAC_TX_TO_MEDIA,
  output logic             TX_ALLOWED,
  output logic             ANEG_RESTART,
  output logic             ANEG_ENABLE,
  output logic             POWER_DOWN,
  output logic             FULL_DUPLEX,
  output logic [1:0]       SPEED,
  output logic             HDX_OFFERED,
  output logic [2:0]       TEST_MODE,
  output logic             MS_MANUAL,
  output logic             MS_MASTER,
  output logic             COLL_TEST,
  output logic             LOOPBACK
);
  localparam int CNT_W = pbr_pkg::SRST_CNT_W;
  logic [15:0]            ctrl_r;
  logic [15:0]            adv_r;
  logic [15:0]            nptx_r;
  logic [15:0]            gctl_r;
  logic [15:0]            rdata_r;
  logic [15:0]            lpa_r;
  logic [15:0]            lpnp_r;
  logic                   toggle_r;
  logic                   restart_r;
  logic [CNT_W-1:0]       srst_cnt_r;
  logic                   soft_rst;
  logic                   wr_ctrl;
  logic                   wr_adv;
  logic                   wr_nptx;
  logic                   wr_gctl;
  logic                   rd_stat;
  logic                   rd_exp;
  logic                   link_q;
  logic                   fault_q;
  logic                   jab_q;
  logic                   pdf_q;
  logic                   page_q;
  logic [15:0]            stat_word;
  logic [15:0]            exp_word;
  logic [15:0]            nptx_word;
  logic [15:0]            rd_mux;
  logic                   bus_ok;
  logic                   isolate;
  localparam int SRST_CNT = pbr_pkg::SRST_CYCLES;
  localparam logic [CNT_W-1:0] SRST_LOAD = CNT_W'(SRST_CNT);

  // Masked merge keeps read-only and reserved bits
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // Accesses during the software-reset wait are dropped
  assign bus_ok  = (srst_cnt_r == '0);
  assign wr_ctrl = CE && bus_ok && REG_WE && REG_ADDR == pbr_pkg::ADDR_CTRL;
  assign wr_adv  = CE && bus_ok && REG_WE && REG_ADDR == pbr_pkg::ADDR_ADV;
  assign wr_nptx = CE && bus_ok && REG_WE && REG_ADDR == pbr_pkg::ADDR_NPTX;
  assign wr_gctl = CE && bus_ok && REG_WE && REG_ADDR == pbr_pkg::ADDR_GCTL;
  assign rd_stat = bus_ok && REG_RE && REG_ADDR == pbr_pkg::ADDR_STAT;
  assign rd_exp  = bus_ok && REG_RE && REG_ADDR == pbr_pkg::ADDR_EXP;
  assign soft_rst = wr_ctrl && REG_WDATA[pbr_pkg::CTL_RESET_BIT];
  assign REG_BUSY = !bus_ok;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      srst_cnt_r <= '0;
    end else if (CE) begin
      if (soft_rst) begin
        srst_cnt_r <= SRST_LOAD;
      end else if (!bus_ok) begin
        srst_cnt_r <= srst_cnt_r - 1'b1;
      end
    end
  end

  // Reset and restart bits never store: they read back as zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_r <= pbr_pkg::CTL_RST;
      adv_r  <= pbr_pkg::ADV_RST;
      nptx_r <= pbr_pkg::NPTX_RST;
      gctl_r <= pbr_pkg::GCTL_RST;
    end else if (CE) begin
      if (soft_rst) begin
        ctrl_r <= pbr_pkg::CTL_RST;
        adv_r  <= pbr_pkg::ADV_RST;
        nptx_r <= pbr_pkg::NPTX_RST;
        gctl_r <= pbr_pkg::GCTL_RST;
      end else begin
        if (wr_ctrl) begin
          ctrl_r <= merge(ctrl_r, REG_WDATA, pbr_pkg::CTL_WMASK) &
                    16'h7DFF;
        end
        if (wr_adv) begin
          adv_r <= merge(adv_r, REG_WDATA, pbr_pkg::ADV_WMASK);
        end
        if (wr_nptx) begin
          nptx_r <= merge(nptx_r, REG_WDATA, pbr_pkg::NPTX_WMASK);
        end
        if (wr_gctl) begin
          gctl_r <= REG_WDATA;
        end
      end
    end
  end

  // Restart pulse is one cycle wide; the stored bit reads 0
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      restart_r <= 1'b0;
    end else if (CE) begin
      restart_r <= wr_ctrl && !soft_rst &&
                   REG_WDATA[pbr_pkg::CTL_RESTART];
    end
  end

  // Toggle flips on each sent page; read value is the inverse
  // Partner pages snapshot on page arrival, hold otherwise
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      toggle_r <= 1'b1; // Toggle reads 0 until a page is sent
      lpa_r    <= '0;
      lpnp_r   <= '0;
    end else if (CE) begin
      if (NP_SENT) begin
        toggle_r <= nptx_word[11];
      end
      if (PAGE_RX) begin
        lpa_r  <= LINK_PARTNER_BASE;
        lpnp_r <= LINK_PARTNER_NEXT;
      end
    end
  end

  // Sticky status bits survive software reset
  pbr_latch #(.HOLD_VAL(1'b0)) u_link (
    .CLK(CLK), .NRST(NRST), .CE(CE), .CLR(1'b0),
    .COND(LINK_UP), .RD(rd_stat), .Q(link_q));
  pbr_latch #(.HOLD_VAL(1'b1)) u_fault (
    .CLK(CLK), .NRST(NRST), .CE(CE), .CLR(1'b0),
    .COND(FAR_FAULT), .RD(rd_stat), .Q(fault_q));
  pbr_latch #(.HOLD_VAL(1'b1)) u_jab (
    .CLK(CLK), .NRST(NRST), .CE(CE), .CLR(1'b0),
    .COND(JABBER), .RD(rd_stat), .Q(jab_q));
  pbr_latch #(.HOLD_VAL(1'b1)) u_pdf (
    .CLK(CLK), .NRST(NRST), .CE(CE), .CLR(1'b0),
    .COND(PAR_DET_FAULT), .RD(rd_exp), .Q(pdf_q));
  pbr_latch #(.HOLD_VAL(1'b1)) u_page (
    .CLK(CLK), .NRST(NRST), .CE(CE), .CLR(1'b0),
    .COND(PAGE_RX), .RD(rd_exp), .Q(page_q));

  // Fixed capabilities plus live and latched bits
  assign stat_word = pbr_pkg::STAT_FIXED |
                     {10'h000, ANEG_DONE, fault_q, 1'b0, link_q,
                      jab_q, 1'b0} |
                     {8'h00, FIBER_MODE, 7'h00};
  assign exp_word  = {11'h000, pdf_q, LINK_PARTNER_NP, 1'b0, page_q,
                      LINK_PARTNER_AN} | pbr_pkg::EXP_NP_ABLE;
  assign nptx_word = {nptx_r[15:12], ~toggle_r, nptx_r[10:0]};

  always_comb begin
    case (REG_ADDR)
      pbr_pkg::ADDR_CTRL: rd_mux = ctrl_r;
      pbr_pkg::ADDR_STAT: rd_mux = stat_word;
      pbr_pkg::ADDR_IDH:  rd_mux = ORG_ID_HIGH;
      pbr_pkg::ADDR_IDL:  rd_mux = {ORG_ID_LOW, MODEL_NUM, REVISION};
      pbr_pkg::ADDR_ADV:  rd_mux = adv_r;
      pbr_pkg::ADDR_LPA:  rd_mux = lpa_r;
      pbr_pkg::ADDR_EXP:  rd_mux = exp_word;
      pbr_pkg::ADDR_NPTX: rd_mux = nptx_word;
      pbr_pkg::ADDR_LPNP: rd_mux = lpnp_r;
      pbr_pkg::ADDR_GCTL: rd_mux = gctl_r;
      default:            rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_r <= '0;
    end else if (CE && REG_RE && bus_ok) begin
      rdata_r <= rd_mux;
    end
  end
  assign REG_RDATA = rdata_r;

  // Mode outputs steered by control bits; half-duplex offer gated by the TS, crypto and EEE inputs
  assign isolate      = ctrl_r[pbr_pkg::CTL_ISOLATE];
  assign MAC_OUT_OE_N = isolate;
  assign MAC_RX_OUT   = isolate ? 8'h00 : MAC_RX_IN;
  assign MAC_TX_TO_MEDIA = isolate ? 8'h00 : MAC_TX_DATA;
  assign ANEG_RESTART = restart_r;
  assign ANEG_ENABLE  = ctrl_r[pbr_pkg::CTL_ANEG_EN];
  assign POWER_DOWN   = ctrl_r[pbr_pkg::CTL_PDOWN];
  assign FULL_DUPLEX  = ctrl_r[pbr_pkg::CTL_DUPLEX];
  assign SPEED = {ctrl_r[pbr_pkg::CTL_SPEED_MSB],
                  ctrl_r[pbr_pkg::CTL_SPEED_LSB]};
  assign COLL_TEST    = ctrl_r[7];
  assign LOOPBACK     = ctrl_r[14];
  // Unidirectional honoured only forced, full duplex, fiber
  assign TX_ALLOWED = !isolate && (link_q || LINK_UP ||
                      (!ANEG_ENABLE && FULL_DUPLEX && FIBER_MODE &&
                       ctrl_r[pbr_pkg::CTL_UNIDIR]));
  assign HDX_OFFERED = !(TS_ACTIVE || CRYPTO_ACTIVE || LEGACY_EEE);
  assign TEST_MODE   = gctl_r[15:13];
  assign MS_MANUAL   = gctl_r[12];
  // Host must set this before forcing gigabit
  assign MS_MASTER   = gctl_r[12] & gctl_r[11];

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  restart_self_clear_a: assert property (
    CE && restart_r |=> !restart_r || $past(wr_ctrl))
    else $error("restart pulse not self clearing");
  restart_reads_zero_a: assert property (
    !ctrl_r[pbr_pkg::CTL_RESTART] && !ctrl_r[pbr_pkg::CTL_RESET_BIT])
    else $error("self clearing bit stored");
  srst_defaults_a: assert property (
    soft_rst |=> ctrl_r == pbr_pkg::CTL_RST && adv_r == pbr_pkg::ADV_RST)
    else $error("soft reset did not restore defaults");
  srst_busy_a: assert property (
    soft_rst |=> REG_BUSY [*8])
    else $error("busy window too short after soft reset");
  isolate_out_a: assert property (
    isolate |-> MAC_OUT_OE_N && MAC_TX_TO_MEDIA == 8'h00)
    else $error("isolated port still drives MAC side");
  link_latch_a: assert property (
    CE && !LINK_UP |=> !link_q)
    else $error("link drop not latched low");
  jabber_hold_a: assert property (
    CE && JABBER && !rd_stat ##1 CE && !rd_stat |=> jab_q)
    else $error("jabber not held high");
  fixed_caps_a: assert property (
    (stat_word & pbr_pkg::STAT_FIXED) == pbr_pkg::STAT_FIXED &&
    stat_word[6] && !stat_word[15])
    else $error("fixed capability bits wrong");
  master_gate_a: assert property (
    !gctl_r[12] |-> !MS_MASTER)
    else $error("master value used without manual bit");
  hdx_block_a: assert property (
    TS_ACTIVE |-> !HDX_OFFERED)
    else $error("half duplex offered with timestamp active");
  ro_bit14_a: assert property (
    wr_adv && !soft_rst |=> !adv_r[14])
    else $error("read-only advertise bit written");
  unidir_a: assert property (
    ANEG_ENABLE && !LINK_UP && !link_q |-> !TX_ALLOWED)
    else $error("transmit allowed without link under negotiation");
  // Sticky latches must hold through every cycle without a read
  link_sticky_a: assert property (
    !link_q && !rd_stat |=> !link_q)
    else $error("link low not held until read");
  fault_sticky_a: assert property (
    fault_q && !rd_stat |=> fault_q)
    else $error("far-end fault not held until read");
  pdf_sticky_a: assert property (
    pdf_q && !rd_exp |=> pdf_q)
    else $error("parallel detect fault not held");
  page_sticky_a: assert property (
    page_q && !rd_exp |=> page_q)
    else $error("page received not held until read");
  toggle_flip_a: assert property (
    CE && NP_SENT |=> nptx_word[11] != $past(nptx_word[11]))
    else $error("next page toggle did not flip");
  partner_capture_a: assert property (
    CE && PAGE_RX |=> lpa_r == $past(LINK_PARTNER_BASE))
    else $error("partner base page not captured");
  duplex_write_a: assert property (
    wr_ctrl && !soft_rst |=>
    FULL_DUPLEX == $past(REG_WDATA[pbr_pkg::CTL_DUPLEX]))
    else $error("forced duplex not taken from write");
  test_mode_a: assert property (
    wr_gctl && !soft_rst |=> TEST_MODE == $past(REG_WDATA[15:13]))
    else $error("test mode not taken from write");

  soft_reset_c: cover property (soft_rst ##1 REG_BUSY);
  link_drop_c: cover property (!LINK_UP ##1 LINK_UP ##1 rd_stat);
  page_rx_c: cover property (PAGE_RX ##1 rd_exp);
  forced_gig_c: cover property (SPEED == pbr_pkg::SPD_1000 && MS_MASTER);
  unidir_c: cover property (TX_ALLOWED && !LINK_UP && !link_q);
endmodule // pbr_regs
`default_nettype wire

//--- pbr_host.sv
// Management host model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module pbr_host (
  input  wire logic        CLK,
  output logic             REG_WE,
  output logic             REG_RE,
  output logic [4:0]       REG_ADDR,
  output logic [15:0]      REG_WDATA,
  input  wire logic [15:0] REG_RDATA
);
  initial begin
    REG_WE    = 1'b0;
    REG_RE    = 1'b0;
    REG_ADDR  = 5'h1F;
    REG_WDATA = 16'h0000;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CLK) {REG_ADDR, REG_WDATA, REG_WE} <= {a, d, 1'b1};
    @(posedge CLK) {REG_ADDR, REG_WDATA, REG_WE} <= {~a, ~d, 1'b0};
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge CLK) {REG_ADDR, REG_RE} <= {a, 1'b1};
    @(posedge CLK) {REG_ADDR, REG_RE} <= {~a, 1'b0};
    #1 d = REG_RDATA;
  endtask
endmodule // pbr_host
`default_nettype wire

//--- tb.sv
// Self-checking bench for the base management register set
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [15:0] ID_HI = 16'hC0DE; // Arbitrary value
  localparam logic [5:0]  ID_LO = 6'h0B;    // Arbitrary value
  localparam logic [5:0]  ID_MD = 6'h22;    // Arbitrary value
  localparam logic [3:0]  ID_RV = 4'h5;     // Arbitrary value
  localparam logic [15:0] ST    = 16'h7949;
  logic        clk = 1'b0, nrst = 1'b0, ce = 1'b1;
  logic        we, re, busy, link = 1'b0, ff = 1'b0, jab = 1'b0;
  logic        pdf = 1'b0, prx = 1'b0, npa = 1'b0, ana = 1'b0, nps = 1'b0;
  logic        fib = 1'b0, ts = 1'b0, cry = 1'b0, eee = 1'b0;
  logic [4:0]  addr;
  logic [15:0] wd, rdat, v, lpb = 16'h0000, lpn = 16'h0000;
  logic [7:0]  mrx = 8'h00, mtx = 8'h00, mrx_o, mtx_o;
  logic        oe_n, txa, rsp, ane, pdn, fdx, hdx, msm, msv, ct, lb;
  logic [1:0]  spd;
  logic [2:0]  tm;
  int          error_cnt = 0;
  int          comparisons = 0;
  always #4 clk = ~clk;
  pbr_regs #(.ORG_ID_HIGH(ID_HI), .ORG_ID_LOW(ID_LO), .MODEL_NUM(ID_MD),
    .REVISION(ID_RV)) dut_u (
    .CLK(clk), .NRST(nrst), .CE(ce), .REG_WE(we), .REG_RE(re),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_BUSY(busy),
    .LINK_UP(link), .FAR_FAULT(ff), .JABBER(jab), .ANEG_DONE(1'b0),
    .PAR_DET_FAULT(pdf), .PAGE_RX(prx), .LINK_PARTNER_BASE(lpb),
    .LINK_PARTNER_NEXT(lpn), .LINK_PARTNER_NP(npa), .LINK_PARTNER_AN(ana),
    .NP_SENT(nps), .FIBER_MODE(fib), .TS_ACTIVE(ts), .CRYPTO_ACTIVE(cry),
    .LEGACY_EEE(eee), .MAC_RX_IN(mrx), .MAC_TX_DATA(mtx),
    .MAC_RX_OUT(mrx_o), .MAC_OUT_OE_N(oe_n), .MAC_TX_TO_MEDIA(mtx_o),
    .TX_ALLOWED(txa), .ANEG_RESTART(rsp), .ANEG_ENABLE(ane),
    .POWER_DOWN(pdn), .FULL_DUPLEX(fdx), .SPEED(spd), .HDX_OFFERED(hdx),
    .TEST_MODE(tm), .MS_MANUAL(msm), .MS_MASTER(msv), .COLL_TEST(ct),
    .LOOPBACK(lb));
  pbr_host host_u (.CLK(clk), .REG_WE(we), .REG_RE(re), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_RDATA(rdat));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    host_u.rd(a, v);
    chk(v, exp);
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset;
    rchk(5'h00, 16'h1040);
    chk({15'h0, ane}, 16'h0001);
    rchk(5'h01, ST);
    rchk(5'h02, ID_HI);
    rchk(5'h03, {ID_LO, ID_MD, ID_RV});
    rchk(5'h04, 16'h01E1);
    rchk(5'h05, 16'h0000);
    rchk(5'h06, 16'h0004);
    rchk(5'h07, 16'h2001);
    rchk(5'h08, 16'h0000);
    rchk(5'h09, 16'h0700);
    rchk(5'h0A, 16'h0000);
  endtask
  task automatic t_ro_writes;
    host_u.wr(5'h04, 16'hFFFF);
    rchk(5'h04, 16'hBFFF);
    host_u.wr(5'h01, 16'h0000);
    rchk(5'h01, ST);
    host_u.wr(5'h05, 16'hFFFF);
    rchk(5'h05, 16'h0000);
    host_u.wr(5'h08, 16'hFFFF);
    rchk(5'h08, 16'h0000);
    host_u.wr(5'h07, 16'hFFFF);
    rchk(5'h07, 16'hB7FF);
  endtask
  task automatic t_ctrl;
    logic [15:0] w;
    host_u.wr(5'h09, 16'h1800);
    chk({14'h0, msm, msv}, 16'h0003);
    host_u.wr(5'h09, 16'h0800);
    chk({14'h0, msm, msv}, 16'h0000);
    host_u.wr(5'h09, 16'h1800);
    for (int s = 0; s < 4; s++) begin
      w = {2'b00, s[0], 4'h0, 1'b1, 1'b0, s[1], 6'h1F};
      host_u.wr(5'h00, w);
      rchk(5'h00, w & 16'hFFE0);
      chk({12'h0, ane, fdx, spd}, {12'h0, 2'b01, s[1:0]});
    end
    host_u.wr(5'h00, 16'h4080);
    chk({14'h0, lb, ct}, 16'h0003);
    host_u.wr(5'h00, 16'h0800);
    chk({14'h0, fdx, pdn}, 16'h0001);
  endtask
  task automatic t_isolate;
    @(posedge clk) {mrx, mtx} <= 16'h5AA5;
    host_u.wr(5'h00, 16'h1400);
    chk({7'h0, oe_n, mrx_o}, 16'h0100);
    chk({8'h0, mtx_o}, 16'h0000);
    host_u.wr(5'h00, 16'h1000);
    chk({7'h0, oe_n, mrx_o}, 16'h005A);
    chk({8'h0, mtx_o}, 16'h00A5);
  endtask
  task automatic t_restart;
    int n;
    n = 0;
    host_u.wr(5'h00, 16'h1200);
    for (int i = 0; i < 4; i++) begin
      if (rsp === 1'b1)
        n++;
      #8;
    end
    chk(16'(n), 16'h0001);
    rchk(5'h00, 16'h1000);
  endtask
  task automatic t_unidir;
    host_u.wr(5'h00, 16'h0120);
    @(posedge clk) fib <= 1'b1;
    #1 chk({15'h0, txa}, 16'h0001);
    rchk(5'h01, ST | 16'h0080);
    @(posedge clk) fib <= 1'b0;
    #1 chk({15'h0, txa}, 16'h0000);
    @(posedge clk) fib <= 1'b1;
    host_u.wr(5'h00, 16'h0020);
    chk({15'h0, txa}, 16'h0000);
    host_u.wr(5'h00, 16'h1120);
    chk({15'h0, txa}, 16'h0000);
    @(posedge clk) {link, fib} <= 2'b10;
    #1 chk({15'h0, txa}, 16'h0001);
  endtask
  task automatic t_hdx;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {ts, cry, eee} <= (i == 3) ? 3'b000 : 3'(3'b001 << i);
      #1 chk({15'h0, hdx}, {15'h0, i == 3});
    end
  endtask
  task automatic t_latch;
    host_u.rd(5'h01, v);
    rchk(5'h01, ST | 16'h0004);
    @(posedge clk) link <= 1'b0;
    @(posedge clk) {link, ff, jab, pdf} <= 4'hF;
    @(posedge clk) {ff, jab, pdf} <= 3'h0;
    host_u.wr(5'h00, 16'h1800);
    chk({15'h0, pdn}, 16'h0001);
    host_u.wr(5'h00, 16'h1000);
    rchk(5'h01, ST | 16'h0012);
    rchk(5'h01, ST | 16'h0004);
    rchk(5'h06, 16'h0014);
    rchk(5'h06, 16'h0004);
    @(posedge clk) {lpb, lpn, npa, ana, prx} <= {32'hC5E1B123, 3'b111};
    @(posedge clk) {lpb, lpn, prx} <= 33'h0;
    rchk(5'h05, 16'hC5E1);
    rchk(5'h08, 16'hB123);
    rchk(5'h06, 16'h000F);
    rchk(5'h06, 16'h000D);
    @(posedge clk) nps <= 1'b1;
    @(posedge clk) nps <= 1'b0;
    rchk(5'h07, 16'hBFFF);
  endtask
  task automatic t_test_modes;
    for (int m = 0; m < 8; m++) begin
      host_u.wr(5'h09, {m[2:0], 13'h0000});
      chk({13'h0, tm}, 16'(m));
    end
  endtask
  task automatic t_soft_reset;
    int n;
    host_u.wr(5'h04, 16'h0000);
    host_u.wr(5'h00, 16'h8000);
    chk({15'h0, busy}, 16'h0001);
    // Accesses during the busy span are dropped, so wait it out
    for (n = 0; n < 400 && busy !== 1'b0; n++)
      #8;
    if (n == 400) begin
      error_cnt++;
      wrap_up;
    end
    rchk(5'h00, 16'h1040);
    rchk(5'h04, 16'h01E1);
    rchk(5'h09, 16'h0700);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_ro_writes;
    t_ctrl;
    t_isolate;
    t_restart;
    t_unidir;
    t_hdx;
    t_latch;
    t_test_modes;
    t_soft_reset;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
endmodule // tb
`default_nettype wire
